// file: psc_pkg.sv
package psc_pkg;

  // Signature words that arm an operation, and the value a finished save reads back
  localparam logic [31:0] SIG_SAVE    = 32'h65766173;
  localparam logic [31:0] SIG_DISCARD = 32'h64616f6c;
  localparam logic [31:0] SIG_REBOOT  = 32'h746f6f62;
  localparam logic [31:0] DONE_VAL    = 32'h00000001;

  // Object indices, each a register index; byte address = 4 * {idx, sub}
  localparam logic [15:0] IDX_STORE   = 16'h1010;
  localparam logic [15:0] IDX_RESTORE = 16'h1011;
  localparam logic [15:0] IDX_MARKER  = 16'h1020;
  localparam logic [15:0] IDX_REBOOT  = 16'h2800;
  localparam logic [15:0] IDX_IRQ_ST  = 16'h3f00;
  localparam logic [15:0] IDX_IRQ_MSK = 16'h3f01;
  localparam logic [15:0] IDX_STATUS  = 16'h3f02;

  // Address field layout
  localparam int ADDR_W   = 26;
  localparam int SUB_LSB  = 2;
  localparam int SUB_MSB  = 9;
  localparam int IDX_LSB  = 10;
  localparam int IDX_MSB  = 25;

  // Subindex codes
  localparam logic [7:0] SUB_COUNT  = 8'h00;
  localparam logic [7:0] SUB_ALL    = 8'h01;
  localparam logic [7:0] SUB_FIRST  = 8'h02;
  localparam logic [7:0] SUB_LAST   = 8'h06;
  localparam logic [7:0] SUB_DATE   = 8'h01;
  localparam logic [7:0] SUB_TIME   = 8'h02;
  localparam logic [7:0] SUB_RBT    = 8'h01;

  // Categories: bit0 comm, bit1 app, bit2 customer, bit3 drive, bit4 tuning
  localparam int          NCAT        = 5;
  localparam logic [4:0]  CAT_ALL     = 5'h1f;
  localparam logic [4:0]  CAT_FACTORY = 5'h0f;
  localparam logic [4:0]  CAT_ONE     = 5'h01;

  // Non-volatile operation codes
  localparam logic [1:0] OP_LOAD    = 2'h0;
  localparam logic [1:0] OP_SAVE    = 2'h1;
  localparam logic [1:0] OP_DISCARD = 2'h2;

  // Interrupt status bits
  localparam int IRQ_SAVE    = 0;
  localparam int IRQ_DISCARD = 1;
  localparam int IRQ_MARKCLR = 2;
  localparam int IRQ_LOAD    = 3;
  localparam int NIRQ        = 4;

  // Reset values
  localparam logic [31:0] MARK_RST = 32'h00000000;
  localparam logic [4:0]  PEND_RST = 5'h00;
  localparam logic [3:0]  IRQ_RST  = 4'h0;

  typedef enum logic [2:0] {
    PSC_BOOT = 3'b001,
    PSC_IDLE = 3'b010,
    PSC_BUSY = 3'b100
  } psc_state_t;

endpackage

// file: psc_trig.sv
`timescale 1ns/1ps
module psc_trig (
  input  wire logic        wr_en,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] signature,
  input  wire logic [7:0]  sub,
  input  wire logic [7:0]  sub_lo,
  input  wire logic [7:0]  sub_hi,
  output logic             hit
);
  // Any other value leaves the operation unarmed
  assign hit = wr_en && (wdata == signature)
               && (sub >= sub_lo) && (sub <= sub_hi);
endmodule // psc_trig

// file: psc_ctrl.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - Save object has one subindex per category; signature starts saving it.
// - Finished save turns the triggering subindex value into 1.
// - Save subindex 1 all, 2 comm, 3 app, 4 customer, 5 drive, 6 tuning.
// - Discard signature in a subindex marks that category's saved values deleted.
// - Discard subindex 1 resets all but tuning; 2 to 6 single categories.
// - Tuning saved values are discarded only through discard subindex 6.
// - Discard leaves active values alone; effect only after next restart.
// - Restart signature in reboot subindex 1 pulses restart_req for one cycle.
// - Marker entries hold date and time, saved along with save-all.
// - Any savable write clears markers, except save subindex 1 and marker.
// - Saved values reload automatically at every reset.
// - Storage handles whole categories only, never single objects.
module psc_ctrl (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [psc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  input  wire logic                        obj_write_evt,
  output logic                             nv_req,
  output logic [1:0]                       nv_op,
  output logic [psc_pkg::NCAT-1:0]         nv_cat,
  output logic                             nv_mark_en,
  output logic [31:0]                      nv_mark_date,
  output logic [31:0]                      nv_mark_time,
  input  wire logic                        nv_ack,
  input  wire logic [31:0]                 nv_ld_date,
  input  wire logic [31:0]                 nv_ld_time,
  output logic                             restart_req,
  output logic                             irq
);
  import psc_pkg::*;

  psc_state_t          state_q;
  logic                pready_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic                nv_req_q;
  logic [1:0]          nv_op_q;
  logic [NCAT-1:0]     nv_cat_q;
  logic                nv_mark_en_q;
  logic [7:0]          act_sub_q;
  logic [31:0]         mark_date_q;
  logic [31:0]         mark_time_q;
  logic [NCAT-1:0]     pend_q;
  logic                restart_q;
  logic [NIRQ-1:0]     irq_st_q;
  logic [NIRQ-1:0]     irq_msk_q;
  logic [NIRQ-1:0]     irq_set;
  logic                irq_q;
  logic [15:0]         idx;
  logic [7:0]          sub;
  logic                wr_en;
  logic                rd_en;
  logic                save_hit;
  logic                disc_hit;
  logic                rbt_hit;
  logic                idle;
  logic                mark_wr;
  logic                mark_clr;
  logic                mapped;
  logic [31:0]         rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign idx   = paddr[IDX_MSB:IDX_LSB];
  assign sub   = paddr[SUB_MSB:SUB_LSB];
  assign wr_en = psel && penable && pready_q && pwrite;
  assign rd_en = psel && penable && pready_q && !pwrite;
  assign idle  = (state_q == PSC_IDLE);

  function automatic logic [NCAT-1:0] cat_of(input logic [7:0] s,
                                             input logic       disc);
    logic [NCAT-1:0] m;
    m = '0;
    if (s == SUB_ALL) begin
      m = disc ? CAT_FACTORY : CAT_ALL;
    end else if (s >= SUB_FIRST && s <= SUB_LAST) begin
      m = CAT_ONE << (s - SUB_FIRST);
    end
    return m;
  endfunction

  psc_trig u_save_trig (
    .wr_en     (wr_en && idle && idx == IDX_STORE),
    .wdata     (pwdata),
    .signature (SIG_SAVE),
    .sub       (sub),
    .sub_lo    (SUB_ALL),
    .sub_hi    (SUB_LAST),
    .hit       (save_hit)
  );

  psc_trig u_disc_trig (
    .wr_en     (wr_en && idle && idx == IDX_RESTORE),
    .wdata     (pwdata),
    .signature (SIG_DISCARD),
    .sub       (sub),
    .sub_lo    (SUB_ALL),
    .sub_hi    (SUB_LAST),
    .hit       (disc_hit)
  );

  psc_trig u_rbt_trig (
    .wr_en     (wr_en && idx == IDX_REBOOT),
    .wdata     (pwdata),
    .signature (SIG_REBOOT),
    .sub       (sub),
    .sub_lo    (SUB_RBT),
    .sub_hi    (SUB_RBT),
    .hit       (rbt_hit)
  );

  always_comb begin
    mapped = 1'b0;
    rd_mux = '0;
    case (idx)
      IDX_STORE: begin
        mapped = (sub <= SUB_LAST);
        if (sub == SUB_COUNT) begin
          rd_mux = {24'h0, SUB_LAST};
        end else if (state_q == PSC_BUSY && nv_op_q == OP_SAVE
                     && sub == act_sub_q) begin
          rd_mux = SIG_SAVE;
        end else begin
          rd_mux = DONE_VAL;
        end
      end
      IDX_RESTORE: begin
        mapped = (sub <= SUB_LAST);
        if (sub == SUB_COUNT) begin
          rd_mux = {24'h0, SUB_LAST};
        end else begin
          rd_mux = {31'h0, (pend_q & cat_of(sub, 1'b1))
                           == cat_of(sub, 1'b1)};
        end
      end
      IDX_MARKER: begin
        mapped = (sub <= SUB_TIME);
        if (sub == SUB_COUNT) begin
          rd_mux = {24'h0, SUB_TIME};
        end else if (sub == SUB_DATE) begin
          rd_mux = mark_date_q;
        end else begin
          rd_mux = mark_time_q;
        end
      end
      IDX_REBOOT: begin
        mapped = (sub <= SUB_RBT);
        rd_mux = (sub == SUB_COUNT) ? {24'h0, SUB_RBT} : 32'h0;
      end
      IDX_IRQ_ST: begin
        mapped = (sub == SUB_COUNT);
        rd_mux = {{(32-NIRQ){1'b0}}, irq_st_q};
      end
      IDX_IRQ_MSK: begin
        mapped = (sub == SUB_COUNT);
        rd_mux = {{(32-NIRQ){1'b0}}, irq_msk_q};
      end
      IDX_STATUS: begin
        mapped = (sub == SUB_COUNT);
        rd_mux = {{(31-NCAT){1'b0}}, pend_q, state_q != PSC_IDLE};
      end
      default: begin
        mapped = 1'b0;
        rd_mux = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer, one wait state

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      prdata_q  <= (psel && !pwrite && mapped) ? rd_mux : '0;
      pslverr_q <= psel && penable && !pready_q && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: boot load, then save or discard on request

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q      <= PSC_BOOT;
      nv_req_q     <= 1'b0;
      nv_op_q      <= OP_LOAD;
      nv_cat_q     <= '0;
      nv_mark_en_q <= 1'b0;
      act_sub_q    <= '0;
    end else begin
      case (state_q)
        PSC_BOOT: begin
          nv_req_q     <= !nv_ack;
          nv_op_q      <= OP_LOAD;
          nv_cat_q     <= CAT_ALL;
          nv_mark_en_q <= 1'b1;
          if (nv_ack && nv_req_q) begin
            state_q <= PSC_IDLE;
          end
        end
        PSC_IDLE: begin
          if (save_hit) begin
            state_q      <= PSC_BUSY;
            nv_req_q     <= 1'b1;
            nv_op_q      <= OP_SAVE;
            nv_cat_q     <= cat_of(sub, 1'b0);
            nv_mark_en_q <= (sub == SUB_ALL);
            act_sub_q    <= sub;
          end else if (disc_hit) begin
            state_q      <= PSC_BUSY;
            nv_req_q     <= 1'b1;
            nv_op_q      <= OP_DISCARD;
            nv_cat_q     <= cat_of(sub, 1'b1);
            nv_mark_en_q <= 1'b0;
            act_sub_q    <= sub;
          end
        end
        PSC_BUSY: begin
          if (nv_ack) begin
            state_q  <= PSC_IDLE;
            nv_req_q <= 1'b0;
            act_sub_q <= '0;
          end
        end
        default: begin
          state_q  <= PSC_IDLE;
          nv_req_q <= 1'b0;
        end
      endcase
    end
  end

  // Discards are only remembered; live values change after a restart
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_q <= PEND_RST;
    end else if (state_q == PSC_BUSY && nv_ack && nv_op_q == OP_DISCARD) begin
      pend_q <= pend_q | nv_cat_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= rbt_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modification marker

  assign mark_wr  = wr_en && idx == IDX_MARKER
                    && (sub == SUB_DATE || sub == SUB_TIME);
  // Discard object is not savable, so it leaves the marker alone
  assign mark_clr = obj_write_evt
                    || (wr_en && idx == IDX_STORE && sub >= SUB_FIRST
                        && sub <= SUB_LAST)
                    || (wr_en && idx == IDX_REBOOT && sub == SUB_RBT);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mark_date_q <= MARK_RST;
      mark_time_q <= MARK_RST;
    end else if (state_q == PSC_BOOT && nv_ack && nv_req_q) begin
      mark_date_q <= nv_ld_date;
      mark_time_q <= nv_ld_time;
    end else if (mark_wr) begin
      if (sub == SUB_DATE) begin
        mark_date_q <= pwdata;
      end else begin
        mark_time_q <= pwdata;
      end
    end else if (mark_clr) begin
      mark_date_q <= MARK_RST;
      mark_time_q <= MARK_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, cleared by reading, set beats clear

  always_comb begin
    irq_set              = '0;
    irq_set[IRQ_SAVE]    = state_q == PSC_BUSY && nv_ack && nv_op_q == OP_SAVE;
    irq_set[IRQ_DISCARD] = state_q == PSC_BUSY && nv_ack
                           && nv_op_q == OP_DISCARD;
    irq_set[IRQ_MARKCLR] = mark_clr && !mark_wr;
    irq_set[IRQ_LOAD]    = state_q == PSC_BOOT && nv_ack && nv_req_q;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_st_q <= IRQ_RST;
    end else if (rd_en && idx == IDX_IRQ_ST && sub == SUB_COUNT) begin
      irq_st_q <= irq_set;
    end else begin
      irq_st_q <= irq_st_q | irq_set;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_msk_q <= IRQ_RST;
    end else if (wr_en && idx == IDX_IRQ_MSK && sub == SUB_COUNT) begin
      irq_msk_q <= pwdata[NIRQ-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_st_q & irq_msk_q);
    end
  end

  assign pready       = pready_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;
  assign nv_req       = nv_req_q;
  assign nv_op        = nv_op_q;
  assign nv_cat       = nv_cat_q;
  assign nv_mark_en   = nv_mark_en_q;
  assign nv_mark_date = mark_date_q;
  assign nv_mark_time = mark_time_q;
  assign restart_req  = restart_q;
  assign irq          = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seq_save_go;
    idle && save_hit;
  endsequence

  sequence seq_op_done;
    state_q == PSC_BUSY && nv_ack;
  endsequence

  chk_save_start: assert property (seq_save_go |=> nv_req_q
      && nv_op_q == OP_SAVE && state_q == PSC_BUSY)
    else $error("save request not started");
  chk_save_map: assert property (seq_save_go ##1 1'b1 |->
      nv_cat_q == cat_of($past(sub), 1'b0))
    else $error("save category mask wrong");
  chk_done_one: assert property (seq_op_done |=> idle && !nv_req_q
      && act_sub_q == 8'h00)
    else $error("save completion not flagged");
  chk_factory_tuning: assert property (nv_req_q
      && nv_op_q == OP_DISCARD
      |-> !(nv_cat_q[NCAT-1] && act_sub_q != SUB_LAST))
    else $error("tuning discarded by wrong subindex");
  chk_discard_all: assert property (idle && disc_hit && sub == SUB_ALL
      |=> nv_cat_q == CAT_FACTORY)
    else $error("factory discard mask wrong");
  chk_discard_live: assert property ((seq_op_done and
      (nv_op_q == OP_DISCARD && !mark_wr && !mark_clr))
      |=> $stable(mark_date_q) && $stable(mark_time_q))
    else $error("discard changed live values");
  chk_marker_clear: assert property (mark_clr && !mark_wr
      && state_q != PSC_BOOT |=> mark_date_q == 32'h0
      && mark_time_q == 32'h0)
    else $error("marker not cleared");
  chk_marker_keep: assert property (wr_en && idx == IDX_STORE
      && sub == SUB_ALL && !obj_write_evt && state_q != PSC_BOOT
      |=> $stable(mark_date_q))
    else $error("save-all cleared marker");
  chk_reboot_pulse: assert property (wr_en && idx == IDX_REBOOT
      && sub == SUB_RBT && pwdata != SIG_REBOOT |=> !restart_q)
    else $error("restart without signature");
  chk_reboot_go: assert property (rbt_hit |=> restart_q)
    else $error("restart not requested");
  chk_boot_load: assert property (state_q == PSC_BOOT |->
      nv_op_q == OP_LOAD && (nv_cat_q == CAT_ALL || !nv_req_q))
    else $error("boot load not issued");
  chk_irq_level: assert property (|(irq_st_q & irq_msk_q) |=> irq_q)
    else $error("interrupt not raised");

endmodule // psc_ctrl

// file: psc_nv_model.sv
`timescale 1ns/1ps
module psc_nv_model #(
  parameter logic [31:0] INIT_DATE = 32'h0000a5a5, // Arbitrary image value
  parameter logic [31:0] INIT_TIME = 32'h00005a5a  // Arbitrary image value
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        stall,
  input  wire logic        nv_req,
  input  wire logic [1:0]  nv_op,
  input  wire logic        nv_mark_en,
  input  wire logic [31:0] nv_mark_date,
  input  wire logic [31:0] nv_mark_time,
  output logic             nv_ack,
  output logic [31:0]      nv_ld_date,
  output logic [31:0]      nv_ld_time
);
  import psc_pkg::*;
  logic [1:0]  cnt_q;
  logic [31:0] img_date_q = INIT_DATE;
  logic [31:0] img_time_q = INIT_TIME;
  //////////////////////////////////////////////////////////////////////////
  // Image survives rst, as storage that outlives a restart would
  always @(posedge ref_clk) begin
    if (nv_req && nv_ack && nv_op == OP_SAVE && nv_mark_en) begin
      img_date_q <= nv_mark_date;
      img_time_q <= nv_mark_time;
    end
  end
  assign nv_ld_date = img_date_q;
  assign nv_ld_time = img_time_q;
  //////////////////////////////////////////////////////////////////////////
  // Stall lets the bench look at the busy state; one ack per request
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 2'h0;
      nv_ack <= 1'b0;
    end else begin
      nv_ack <= 1'b0;
      if (nv_req && !nv_ack && !stall) begin
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == 2'h3) begin
          nv_ack <= 1'b1;
        end
      end
    end
  end
endmodule // psc_nv_model

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import psc_pkg::*;
  localparam logic [31:0] BD = 32'h0000a5a5; // Arbitrary boot image
  localparam logic [31:0] BT = 32'h00005a5a; // Arbitrary boot image
  logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [25:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, nv_mark_date, nv_mark_time;
  logic [31:0] nv_ld_date, nv_ld_time, rd_q;
  logic        pready, pslverr, obj_write_evt = 0, nv_req, nv_mark_en;
  logic        nv_ack, restart_req, irq, stall = 1, err_q;
  logic [1:0]  nv_op;
  logic [4:0]  nv_cat, cat, pend;
  logic [7:0]  s;
  int          err_count = 0, checks_done = 0;

  always #2 ref_clk = ~ref_clk;

  psc_ctrl u_psc_ctrl (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .obj_write_evt(obj_write_evt), .nv_req(nv_req), .nv_op(nv_op),
    .nv_cat(nv_cat), .nv_mark_en(nv_mark_en), .nv_mark_date(nv_mark_date),
    .nv_mark_time(nv_mark_time), .nv_ack(nv_ack), .nv_ld_date(nv_ld_date),
    .nv_ld_time(nv_ld_time), .restart_req(restart_req), .irq(irq));
  psc_nv_model #(.INIT_DATE(BD), .INIT_TIME(BT)) u_psc_nv_model (
    .ref_clk(ref_clk), .rst(rst), .stall(stall), .nv_req(nv_req),
    .nv_op(nv_op), .nv_mark_en(nv_mark_en), .nv_mark_date(nv_mark_date),
    .nv_mark_time(nv_mark_time), .nv_ack(nv_ack), .nv_ld_date(nv_ld_date),
    .nv_ld_time(nv_ld_time));
  //////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  // Request held until pready is seen high; released after that edge
  task apb(input logic w, input logic [15:0] i, input logic [7:0] b,
           input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, b, 2'b00};
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    // Sampled at the rising edge, before that edge's updates land
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      conclude();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [15:0] i, input logic [7:0] b, input logic [31:0] d);
    apb(1, i, b, d);
  endtask
  task rdc(input logic [15:0] i, input logic [7:0] b, input logic [31:0] e);
    apb(0, i, b, 32'h0);
    chk(rd_q, e);
  endtask
  task wait_idle;
    int n;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (nv_req !== 1'b0 && n < 50);
    if (nv_req !== 1'b0) begin err_count++; conclude(); end
  endtask
  function logic [31:0] nvw();
    return {23'h0, nv_req, nv_mark_en, nv_op, nv_cat};
  endfunction
  task boot_chk;
    repeat (2) @(negedge ref_clk);
    chk(nvw(), {23'h0, 2'b11, OP_LOAD, CAT_ALL});
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    boot_chk();
    rdc(IDX_STATUS, 8'h00, 32'h1);
    stall <= 0;
    wait_idle();
    rdc(IDX_MARKER, SUB_DATE, BD);
    rdc(IDX_MARKER, SUB_TIME, BT);
    rdc(IDX_STORE, SUB_COUNT, 32'h6);
    rdc(IDX_RESTORE, SUB_COUNT, 32'h6);
    rdc(IDX_MARKER, SUB_COUNT, 32'h2);
    rdc(IDX_REBOOT, SUB_COUNT, 32'h1);
    apb(0, 16'h1234, 8'h00, 32'h0);
    chk(err_q, 1'b1);
    wr(IDX_IRQ_MSK, 8'h00, 32'h1);
    rdc(IDX_IRQ_MSK, 8'h00, 32'h1);
    // Every save code, each stalled to see the busy readback
    for (s = SUB_ALL; s <= SUB_LAST; s++) begin
      cat = (s == SUB_ALL) ? CAT_ALL : CAT_ONE << (s - 2);
      stall <= 1;
      wr(IDX_STORE, s, SIG_SAVE);
      @(negedge ref_clk);
      chk(nvw(), {23'h0, 1'b1, s == SUB_ALL, OP_SAVE, cat});
      rdc(IDX_STORE, s, SIG_SAVE);
      stall <= 0;
      wait_idle();
      repeat (2) @(negedge ref_clk);
      chk(irq, 1'b1);
      rdc(IDX_STORE, s, DONE_VAL);
      apb(0, IDX_IRQ_ST, 8'h00, 32'h0);
      chk(rd_q[IRQ_SAVE], 1'b1);
      repeat (2) @(negedge ref_clk);
      chk(irq, 1'b0);
    end
    // Marker clearing and save-all carrying it
    wr(IDX_MARKER, SUB_DATE, 32'h11);
    wr(IDX_MARKER, SUB_TIME, 32'h22);
    rdc(IDX_MARKER, SUB_DATE, 32'h11);
    wr(IDX_STORE, SUB_FIRST, 32'h0);
    @(negedge ref_clk);
    chk(nv_req, 1'b0);
    rdc(IDX_MARKER, SUB_DATE, 32'h0);
    rdc(IDX_MARKER, SUB_TIME, 32'h0);
    wr(IDX_MARKER, SUB_DATE, 32'h11);
    wr(IDX_MARKER, SUB_TIME, 32'h22);
    stall <= 1;
    wr(IDX_STORE, SUB_ALL, SIG_SAVE);
    @(negedge ref_clk);
    chk(nv_mark_date, 32'h11);
    chk(nv_mark_time, 32'h22);
    stall <= 0;
    wait_idle();
    rdc(IDX_MARKER, SUB_DATE, 32'h11);
    @(posedge ref_clk) obj_write_evt <= 1;
    @(posedge ref_clk) obj_write_evt <= 0;
    rdc(IDX_MARKER, SUB_DATE, 32'h0);
    // Discards with the interrupt masked
    wr(IDX_IRQ_MSK, 8'h00, 32'h0);
    wr(IDX_MARKER, SUB_DATE, 32'h33);
    pend = PEND_RST;
    for (s = SUB_ALL; s <= SUB_LAST; s++) begin
      cat = (s == SUB_ALL) ? CAT_FACTORY : CAT_ONE << (s - 2);
      pend = pend | cat;
      stall <= 1;
      wr(IDX_RESTORE, s, SIG_DISCARD);
      @(negedge ref_clk);
      chk(nvw(), {23'h0, 2'b10, OP_DISCARD, cat});
      stall <= 0;
      wait_idle();
      rdc(IDX_RESTORE, s, 32'h1);
      rdc(IDX_RESTORE, SUB_LAST, {31'h0, pend[4]});
      rdc(IDX_STATUS, 8'h00, {26'h0, pend, 1'b0});
    end
    chk(irq, 1'b0);
    apb(0, IDX_IRQ_ST, 8'h00, 32'h0);
    chk(rd_q[IRQ_DISCARD], 1'b1);
    rdc(IDX_MARKER, SUB_DATE, 32'h33);
    wr(IDX_RESTORE, SUB_FIRST, 32'h0);
    @(negedge ref_clk);
    chk(nv_req, 1'b0);
    // Restart request
    wr(IDX_REBOOT, SUB_RBT, 32'h0);
    @(negedge ref_clk);
    chk(restart_req, 1'b0);
    rdc(IDX_MARKER, SUB_DATE, 32'h0);
    wr(IDX_REBOOT, SUB_RBT, SIG_REBOOT);
    @(negedge ref_clk);
    chk(restart_req, 1'b1);
    @(negedge ref_clk);
    chk(restart_req, 1'b0);
    // Second reset reloads the saved marker; discards take effect
    @(posedge ref_clk) rst <= 1;
    @(posedge ref_clk) rst <= 0;
    boot_chk();
    wait_idle();
    rdc(IDX_MARKER, SUB_DATE, 32'h11);
    rdc(IDX_MARKER, SUB_TIME, 32'h22);
    rdc(IDX_STATUS, 8'h00, 32'h0);
    conclude();
  end
endmodule // tb_top
